// ==== core/sei_dev.sv ====
// eeprom end: link slave on the serial clock, array and write timer on clk
`timescale 1ns/10ps
module sei_dev #(
  parameter int WR_CYCLES = sei_pkg::WR_CYCLES,
  parameter logic [3:0] DEV_TYPE = sei_pkg::DEV_TYPE
) (
  input logic clk,
  input logic reset,
  sei_link_if.dev link,
  input logic cs_high,
  input logic cs_mid,
  input logic cs_low,
  input logic wp,
  output logic busy,
  output logic standby
);
  localparam int CYC_W = $clog2(WR_CYCLES + 1);
  localparam int PB = sei_pkg::PAGE_BYTES;

  // ---------------------------------------------------------------
  // link-side state
  // ---------------------------------------------------------------
  logic sda_p_q;
  logic [7:0] sr_q;
  logic mack_q;
  sei_pkg::sei_dst_e st_q;
  logic [3:0] cnt_q;
  logic oe_n_q;
  logic [sei_pkg::WADDR_W-1:0] addr_q;
  logic [sei_pkg::ROW_W-1:0] row_q;
  logic [7:0] obyte_q;
  logic [7:0] pbuf_q [PB];
  logic [PB-1:0] mask_q;
  logic busy_s1, busy_s2;
  logic csh_s1, csh_s2, csm_s1, csm_s2;

  // ---------------------------------------------------------------
  // clk-side state
  // ---------------------------------------------------------------
  logic scl_s1, scl_s2;
  logic sda_s1, sda_s2, sda_s3;
  logic wp_s1, wp_s2;
  logic pend_s1, pend_s2;
  logic busy_q;
  logic standby_q;
  logic [CYC_W-1:0] cyc_q;
  logic [7:0] mem [sei_pkg::MEM_BYTES];

  // lowest select pin plays no part in addressing
  logic unused_cs;
  assign unused_cs = cs_low;

  // ---------------------------------------------------------------
  // link decode
  // ---------------------------------------------------------------
  // start seen as high at the rise and low at the fall of one pulse
  wire start_w = sda_p_q & ~link.sda;
  // a stop leaves no falling edge, so the link side never sees it
  wire type_ok_w = sr_q[7:4] == DEV_TYPE;
  // bench ties a floating select pin to 0 before it reaches us
  wire sel_ok_w = sr_q[3:2] == {csh_s2, csm_s2};
  // withheld while programming so that the master can poll
  wire hit_w = type_ok_w & sel_ok_w & ~busy_s2;
  wire [7:0] mem_rd_w = mem[addr_q[sei_pkg::MEM_AW-1:0]];
  wire [sei_pkg::PAGE_AW-1:0] slot_w = addr_q[sei_pkg::PAGE_AW-1:0];
  wire [sei_pkg::INC_BITS-1:0] low_inc_w = addr_q[sei_pkg::INC_BITS-1:0] + 5'h01;
  wire [sei_pkg::WADDR_W-1:0] addr_pg_w = {addr_q[9:5], low_inc_w};
  wire [sei_pkg::WADDR_W-1:0] addr_seq_w = addr_q + 10'h001;
  wire [2:0] obit_w = 3'h6 - cnt_q[2:0];

  // open-drain: only ever pull low or release
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe_n = oe_n_q;
  assign busy = busy_q;
  assign standby = standby_q;

  // ---------------------------------------------------------------
  // rising edge: sample data, sync slow pins
  // ---------------------------------------------------------------
  // link clock stops between frames, so reset acts without it
  always_ff @(posedge link.scl or posedge reset) begin
    if (reset) begin
      sda_p_q <= 1'b1;
      sr_q <= 8'h00;
      mack_q <= 1'b1;
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
      csh_s1 <= 1'b0;
      csh_s2 <= 1'b0;
      csm_s1 <= 1'b0;
      csm_s2 <= 1'b0;
    end else begin
      sda_p_q <= link.sda;
      if (cnt_q != sei_pkg::BIT_ACK) begin
        sr_q <= {sr_q[6:0], link.sda};
      end else begin
        mack_q <= link.sda;
      end
      busy_s1 <= busy_q;
      busy_s2 <= busy_s1;
      csh_s1 <= cs_high;
      csh_s2 <= csh_s1;
      csm_s1 <= cs_mid;
      csm_s2 <= csm_s1;
    end
  end

  // ---------------------------------------------------------------
  // falling edge: byte sequencing and output drive
  // ---------------------------------------------------------------
  always_ff @(negedge link.scl or posedge reset) begin
    if (reset) begin
      st_q <= sei_pkg::DS_IDLE;
      cnt_q <= 4'h0;
      oe_n_q <= 1'b1;
      addr_q <= '0;
      row_q <= '0;
      obyte_q <= 8'h00;
      mask_q <= '0;
    end else if (start_w) begin
      // a new start drops any unfinished write
      st_q <= sei_pkg::DS_DEV;
      cnt_q <= 4'h0;
      oe_n_q <= 1'b1;
      mask_q <= '0;
    end else if (st_q == sei_pkg::DS_IDLE) begin
      cnt_q <= 4'h0;
      oe_n_q <= 1'b1;
    end else if (cnt_q == sei_pkg::BIT_LAST) begin
      cnt_q <= sei_pkg::BIT_ACK;
      case (st_q)
        sei_pkg::DS_DEV: begin
          if (hit_w) begin
            oe_n_q <= 1'b0;
          end else begin
            st_q <= sei_pkg::DS_IDLE;
          end
        end
        sei_pkg::DS_AHI: begin
          addr_q[9:8] <= sr_q[1:0];
          oe_n_q <= 1'b0;
        end
        sei_pkg::DS_ALO: begin
          addr_q[7:0] <= sr_q;
          row_q <= {addr_q[8], sr_q[7:4]};
          oe_n_q <= 1'b0;
        end
        sei_pkg::DS_WDAT: begin
          pbuf_q[slot_w] <= sr_q;
          mask_q[slot_w] <= 1'b1;
          addr_q <= addr_pg_w;
          oe_n_q <= 1'b0;
        end
        default: begin
          oe_n_q <= 1'b1;
        end
      endcase
    end else if (cnt_q == sei_pkg::BIT_ACK) begin
      cnt_q <= 4'h0;
      oe_n_q <= 1'b1;
      case (st_q)
        sei_pkg::DS_DEV: begin
          // read bit set: first byte goes out on this same edge
          if (sr_q[0]) begin
            st_q <= sei_pkg::DS_RDAT;
            obyte_q <= mem_rd_w;
            addr_q <= addr_seq_w;
            oe_n_q <= mem_rd_w[7];
          end else begin
            st_q <= sei_pkg::DS_AHI;
          end
        end
        sei_pkg::DS_AHI: st_q <= sei_pkg::DS_ALO;
        sei_pkg::DS_ALO: st_q <= sei_pkg::DS_WDAT;
        sei_pkg::DS_RDAT: begin
          if (!mack_q) begin
            obyte_q <= mem_rd_w;
            addr_q <= addr_seq_w;
            oe_n_q <= mem_rd_w[7];
          end else begin
            st_q <= sei_pkg::DS_IDLE;
          end
        end
        default: st_q <= st_q;
      endcase
    end else begin
      cnt_q <= cnt_q + 4'h1;
      // array is stable here: it only changes while we refuse the bus
      oe_n_q <= (st_q == sei_pkg::DS_RDAT) ? obyte_q[obit_w] : 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // clk side: pin sync and stop detect
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    scl_s1 <= link.scl;
    scl_s2 <= scl_s1;
    sda_s1 <= link.sda;
    sda_s2 <= sda_s1;
    sda_s3 <= sda_s2;
    wp_s1 <= wp;
    wp_s2 <= wp_s1;
    pend_s1 <= |mask_q;
    pend_s2 <= pend_s1;
  end

  wire stop_w = scl_s2 & sda_s2 & ~sda_s3;
  wire start_c_w = scl_s2 & ~sda_s2 & sda_s3;
  // buffer and row are quiet once the clock rests after the stop
  wire commit_w = stop_w & pend_s2 & ~busy_q & ~wp_s2;
  wire cyc_end_w = cyc_q == CYC_W'(WR_CYCLES - 1);

  // ---------------------------------------------------------------
  // write cycle timer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_q <= 1'b0;
      cyc_q <= '0;
    end else if (commit_w) begin
      busy_q <= 1'b1;
      cyc_q <= '0;
    end else if (busy_q) begin
      busy_q <= ~cyc_end_w;
      cyc_q <= cyc_q + CYC_W'(1);
    end
  end

  // ---------------------------------------------------------------
  // array: whole marked page slots land at once, erase implied
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (commit_w) begin
      for (int i = 0; i < PB; i++) begin
        if (mask_q[i]) begin
          mem[{row_q, 4'(i)}] <= pbuf_q[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // standby flag
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      standby_q <= 1'b1;
    end else if (commit_w) begin
      standby_q <= 1'b0;
    end else if (busy_q & cyc_end_w) begin
      standby_q <= 1'b1;
    end else if (stop_w & ~busy_q) begin
      standby_q <= 1'b1;
    end else if (start_c_w & ~busy_q) begin
      standby_q <= 1'b0;
    end
  end
endmodule // sei_dev

// ==== core/sei_pkg.sv ====
// shared constants and types for the two-wire eeprom link
package sei_pkg;
  // ---------------------------------------------------------------
  // array and addressing
  // ---------------------------------------------------------------
  localparam int WADDR_W = 10;
  localparam int MEM_AW = 9;
  localparam int MEM_BYTES = 512;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_AW = 4;
  localparam int ROW_W = MEM_AW - PAGE_AW;
  localparam int INC_BITS = 5;
  localparam logic [3:0] DEV_TYPE = 4'h5; // arbitrary device-type code
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int WR_TIME_MS = 5;
  localparam int WR_CYCLES = WR_TIME_MS * CLK_MHZ * 1000;
  localparam int QTR_CYCLES = 63;
  // ---------------------------------------------------------------
  // state encodings
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_DEV = 3'b001,
    DS_AHI = 3'b010,
    DS_ALO = 3'b011,
    DS_WDAT = 3'b100,
    DS_RDAT = 3'b101
  } sei_dst_e;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_START = 2'b01,
    HS_BYTE = 2'b10,
    HS_STOP = 2'b11
  } sei_hst_e;
  typedef enum logic [2:0] {
    HP_DEV = 3'b000,
    HP_AHI = 3'b001,
    HP_ALO = 3'b010,
    HP_WDAT = 3'b011,
    HP_RDEV = 3'b100,
    HP_RDAT = 3'b101
  } sei_hph_e;
endpackage

// ==== core/sei_link_if.sv ====
// two-wire link between master and eeprom, with pulled-up data line
`timescale 1ns/10ps
interface sei_link_if;
  logic scl;
  logic sda;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  // wired-and with pull-up: a driving end holds its enable low
  assign sda = (dev_sda_oe_n | dev_sda_o) & (host_sda_oe_n | host_sda_o);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport host (output scl, input sda, output host_sda_o, output host_sda_oe_n);
endinterface

// ==== core/sei_host.sv ====
// bus master end: makes the serial clock from clk and runs write/read
`timescale 1ns/10ps
module sei_host #(
  parameter int QTR_CYCLES = sei_pkg::QTR_CYCLES
) (
  input logic clk,
  input logic reset,
  sei_link_if.host link,
  input logic cmd_valid,
  output logic cmd_ready,
  input logic cmd_read,
  input logic [1:0] cmd_dev,
  input logic [9:0] cmd_addr,
  input logic [4:0] cmd_len,
  input logic [7:0] wr_data,
  output logic wr_take,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic nack
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  sei_pkg::sei_hst_e st_q;
  sei_pkg::sei_hph_e ph_q;
  logic [7:0] qcnt_q;
  logic [1:0] q_q;
  logic [3:0] bit_q;
  logic [7:0] tx_q, rx_q;
  logic ack_q, rd_q;
  logic [1:0] dev_q;
  logic [9:0] addr_q;
  logic [4:0] left_q;
  logic scl_q, oe_n_q;
  logic sda_s1, sda_s2;

  // ---------------------------------------------------------------
  // slot timing and pin levels
  // ---------------------------------------------------------------
  wire tick_w = qcnt_q == 8'(QTR_CYCLES - 1);
  wire end_w = tick_w & (q_q == 2'h3);
  wire hi_w = (q_q == 2'h1) | (q_q == 2'h2);
  wire last_w = left_q == 5'h01;
  // host acknowledges read bytes except the last
  wire ackv_w = (ph_q == sei_pkg::HP_RDAT) ? last_w : 1'b1;
  wire bitv_w = (bit_q == sei_pkg::BIT_ACK) ? ackv_w : tx_q[3'h7 - bit_q[2:0]];
  wire [7:0] devw_w = {sei_pkg::DEV_TYPE, dev_q, 1'b0, ph_q == sei_pkg::HP_RDEV};
  logic scl_d, lvl_d;
  // bits change in quarter 0 with the clock low; edges of sda with
  // the clock high happen only in start and stop slots
  always_comb begin
    scl_d = 1'b1;
    lvl_d = 1'b1;
    case (st_q)
      sei_pkg::HS_START: begin
        scl_d = hi_w;
        lvl_d = q_q < 2'h2;
      end
      sei_pkg::HS_BYTE: begin
        scl_d = hi_w;
        lvl_d = bitv_w;
      end
      sei_pkg::HS_STOP: begin
        scl_d = q_q != 2'h0;
        lvl_d = q_q >= 2'h2;
      end
      default: begin
        scl_d = 1'b1;
        lvl_d = 1'b1;
      end
    endcase
  end

  assign link.scl = scl_q;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe_n = oe_n_q;

  // ---------------------------------------------------------------
  // pins and sync
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      scl_q <= 1'b1;
      oe_n_q <= 1'b1;
    end else begin
      scl_q <= scl_d;
      oe_n_q <= lvl_d;
    end
    sda_s1 <= link.sda;
    sda_s2 <= sda_s1;
  end

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= sei_pkg::HS_IDLE;
      ph_q <= sei_pkg::HP_DEV;
      qcnt_q <= 8'h00;
      q_q <= 2'h0;
      bit_q <= 4'h0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      ack_q <= 1'b1;
      rd_q <= 1'b0;
      dev_q <= 2'h0;
      addr_q <= 10'h000;
      left_q <= 5'h00;
      cmd_ready <= 1'b1;
      wr_take <= 1'b0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
    end else begin
      wr_take <= 1'b0;
      rd_valid <= 1'b0;
      done <= 1'b0;
      if (st_q == sei_pkg::HS_IDLE) begin
        qcnt_q <= 8'h00;
        q_q <= 2'h0;
        if (cmd_valid) begin
          st_q <= sei_pkg::HS_START;
          ph_q <= sei_pkg::HP_DEV;
          rd_q <= cmd_read;
          dev_q <= cmd_dev;
          addr_q <= cmd_addr;
          left_q <= cmd_len;
          cmd_ready <= 1'b0;
          nack <= 1'b0;
        end
      end else begin
        qcnt_q <= tick_w ? 8'h00 : qcnt_q + 8'h01;
        if (tick_w) begin
          q_q <= q_q + 2'h1;
        end
        if (tick_w && q_q == 2'h2 && st_q == sei_pkg::HS_BYTE) begin
          if (bit_q == sei_pkg::BIT_ACK) begin
            ack_q <= sda_s2;
          end else begin
            rx_q <= {rx_q[6:0], sda_s2};
          end
        end
        if (end_w) begin
          bit_q <= 4'h0;
          case (st_q)
            sei_pkg::HS_START: begin
              st_q <= sei_pkg::HS_BYTE;
              tx_q <= devw_w;
            end
            sei_pkg::HS_STOP: begin
              st_q <= sei_pkg::HS_IDLE;
              done <= 1'b1;
              cmd_ready <= 1'b1;
            end
            default: begin
              if (bit_q != sei_pkg::BIT_ACK) begin
                bit_q <= bit_q + 4'h1;
              end else if (ph_q != sei_pkg::HP_RDAT && ack_q) begin
                // busy device or no match: caller may retry to poll
                nack <= 1'b1;
                st_q <= sei_pkg::HS_STOP;
              end else begin
                case (ph_q)
                  sei_pkg::HP_DEV: begin
                    ph_q <= sei_pkg::HP_AHI;
                    tx_q <= {6'h00, addr_q[9:8]};
                  end
                  sei_pkg::HP_AHI: begin
                    ph_q <= sei_pkg::HP_ALO;
                    tx_q <= addr_q[7:0];
                  end
                  sei_pkg::HP_ALO: begin
                    if (rd_q) begin
                      ph_q <= sei_pkg::HP_RDEV;
                      st_q <= sei_pkg::HS_START;
                    end else if (left_q == 5'h00) begin
                      st_q <= sei_pkg::HS_STOP;
                    end else begin
                      ph_q <= sei_pkg::HP_WDAT;
                      tx_q <= wr_data;
                      wr_take <= 1'b1;
                    end
                  end
                  sei_pkg::HP_WDAT: begin
                    left_q <= left_q - 5'h01;
                    if (last_w) begin
                      st_q <= sei_pkg::HS_STOP;
                    end else begin
                      tx_q <= wr_data;
                      wr_take <= 1'b1;
                    end
                  end
                  sei_pkg::HP_RDEV: begin
                    ph_q <= sei_pkg::HP_RDAT;
                    tx_q <= 8'hFF;
                  end
                  default: begin
                    rd_data <= rx_q;
                    rd_valid <= 1'b1;
                    left_q <= left_q - 5'h01;
                    if (last_w) begin
                      st_q <= sei_pkg::HS_STOP;
                    end
                  end
                endcase
              end
            end
          endcase
        end
      end
    end
  end
endmodule // sei_host

// ==== bench/sei_link_assertions.sv ====
// concurrent checks on the two-wire link and the eeprom write timer
`timescale 1ns/10ps
module sei_link_assertions #(
  parameter int WR_CYCLES = sei_pkg::WR_CYCLES
) (
  input logic clk,
  input logic reset,
  input logic scl,
  input logic sda,
  input logic dev_sda_o,
  input logic dev_sda_oe_n,
  input logic host_sda_o,
  input logic host_sda_oe_n,
  input logic busy,
  input logic standby
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ---------------------------------------------------------------
  // helper: cycles spent in the current write cycle
  // ---------------------------------------------------------------
  int busy_cnt_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= busy ? busy_cnt_q + 1 : 0;
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_DEV_OPEN_DRAIN: assert property (!dev_sda_o)
    else $error("device drives the data line high");
  AST_DEV_FALL_EDGE: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device data changed with clock high");
  AST_HOST_LOW_CHANGE: assert property ($changed(host_sda_oe_n) && scl |-> $past(scl, 2))
    else $error("master data changed outside start or stop");
  AST_QUIET_BUSY: assert property (busy |-> dev_sda_oe_n)
    else $error("device answered while programming");
  AST_BUSY_AWAKE: assert property (busy |-> !standby)
    else $error("standby raised during programming");
  AST_WR_LEN: assert property ($fell(busy) |-> busy_cnt_q == WR_CYCLES)
    else $error("write cycle length wrong");
  AST_END_STANDBY: assert property ($fell(busy) |-> ##[0:2] standby)
    else $error("no standby after programming");
  AST_START_WAKE: assert property ($fell(sda) && scl && !busy |-> ##[1:8] !standby)
    else $error("start not seen by device");
  AST_STOP_SETTLE: assert property ($rose(sda) && scl |-> ##[1:10] (standby || busy))
    else $error("stop left device neither idle nor programming");
  // main scenarios reached
  COV_PROG: cover property ($rose(busy));
  COV_START: cover property ($fell(sda) && scl);
  COV_ACK: cover property ($fell(dev_sda_oe_n));
endmodule // sei_link_assertions

// ==== bench/testbench.sv ====
// self-checking bench: host and eeprom ends joined over the two-wire link
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("Error t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
module testbench;
  // ---------------------------------------------------------------
  // stimulus, model state and counters
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL = 2'h2;
  logic clk = 1'b0;
  logic reset = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [1:0] cmd_dev = 2'h0;
  logic [9:0] cmd_addr = 10'h000;
  logic [4:0] cmd_len = 5'h00;
  logic [7:0] wr_data = 8'h00;
  logic cs_high = 1'b1;
  logic cs_mid = 1'b0;
  logic cs_low = 1'b0;
  logic wp = 1'b0;
  logic cmd_ready, wr_take, rd_valid, done, nack, busy, standby;
  logic [7:0] rd_data;
  logic [7:0] mem_m [512];
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  logic [7:0] lfsr_q = 8'h0E;
  int wi = 0;
  int cyc = 0;
  int error_cnt = 0;
  int total_checks = 0;
  initial begin
    forever #2 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // both ends, the link and its checker
  // ---------------------------------------------------------------
  sei_link_if u_sei_link_if ();
  sei_dev #(.WR_CYCLES(200)) u_sei_dev (.clk(clk), .reset(reset), .link(u_sei_link_if),
    .cs_high(cs_high), .cs_mid(cs_mid), .cs_low(cs_low), .wp(wp), .busy(busy),
    .standby(standby));
  sei_host #(.QTR_CYCLES(4)) u_sei_host (.clk(clk), .reset(reset), .link(u_sei_link_if),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_dev(cmd_dev),
    .cmd_addr(cmd_addr), .cmd_len(cmd_len), .wr_data(wr_data), .wr_take(wr_take),
    .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .nack(nack));
  sei_link_assertions #(.WR_CYCLES(200)) u_sei_link_assertions (.clk(clk), .reset(reset),
    .scl(u_sei_link_if.scl), .sda(u_sei_link_if.sda), .dev_sda_o(u_sei_link_if.dev_sda_o),
    .dev_sda_oe_n(u_sei_link_if.dev_sda_oe_n), .host_sda_o(u_sei_link_if.host_sda_o),
    .host_sda_oe_n(u_sei_link_if.host_sda_oe_n), .busy(busy), .standby(standby));
  // next byte stays ready ahead, since the host latches it with its take pulse
  always @(posedge clk) begin
    if (wr_take === 1'b1 && wi + 1 < wq.size()) begin
      wi <= wi + 1;
      wr_data <= wq[wi + 1];
    end
  end
  // gather read bytes; a hang is cut short here
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rd_valid === 1'b1) begin
      rq.push_back(rd_data);
    end
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // one host command, waiting for its done under a bound
  task automatic run_cmd(input logic rd, input logic [1:0] dv, input logic [9:0] ad,
                         input logic [4:0] ln);
    int n;
    n = 0;
    rq.delete();
    wi = 0;
    @(posedge clk);
    cmd_read <= rd;
    cmd_dev <= dv;
    cmd_addr <= ad;
    cmd_len <= ln;
    if (wq.size() > 0) begin
      wr_data <= wq[0];
    end
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 20000);
    // a command that never ends is a failure, not a silent skip
    if (n >= 20000) begin
      error_cnt++;
    end
    `CHK(cmd_ready, 1'b1)
  endtask
  // random bytes into one page; the model wraps inside the page row
  task automatic wr_page(input logic [9:0] ad, input int cnt, input bit commit);
    wq.delete();
    for (int i = 0; i < cnt; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      wq.push_back(lfsr_q);
    end
    run_cmd(1'b0, SEL, ad, 5'(cnt));
    `CHK(nack, 1'b0)
    for (int i = 0; i < cnt && commit; i++) begin
      mem_m[{ad[8:4], 4'(ad[3:0] + i)}] = wq[i];
    end
  endtask
  // sequential read compared byte by byte with the model
  task automatic rd_chk(input logic [9:0] ad, input int cnt);
    run_cmd(1'b1, SEL, ad, 5'(cnt));
    `CHK(nack, 1'b0)
    `CHK(rq.size(), cnt)
    for (int i = 0; i < cnt; i++) begin
      `CHK(rq[i], mem_m[9'(ad[8:0] + i)])
    end
  endtask
  // bounded wait for the write cycle, plus margin for the link sync
  task automatic wait_prog();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 1000) begin
      error_cnt++;
    end
    repeat (80) @(negedge clk);
    `CHK(standby, 1'b1)
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    // a start value raises no edge; the link-clock flops need a real one
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    // every select code; the lowest strap takes random levels
    for (int d = 0; d < 4; d++) begin
      @(posedge clk);
      lfsr_q = lfsr_next(lfsr_q);
      cs_low <= lfsr_q[0];
      run_cmd(1'b0, 2'(d), 10'h000, 5'h00);
      `CHK(nack, (d != 2) ? 1'b1 : 1'b0)
    end
    // eighteen bytes into a sixteen-byte page, then poll at once
    wr_page(10'h0A5, 18, 1'b1);
    run_cmd(1'b0, SEL, 10'h000, 5'h00);
    `CHK(nack, 1'b1)
    wait_prog();
    run_cmd(1'b0, SEL, 10'h000, 5'h00);
    `CHK(nack, 1'b0)
    wait_prog();
    // protected: reads work, writes are acked but dropped
    @(posedge clk);
    wp <= 1'b1;
    rd_chk(10'h0A0, 16);
    wr_page(10'h0A0, 2, 1'b0);
    repeat (20) @(negedge clk);
    `CHK(busy, 1'b0)
    rd_chk(10'h0A0, 2);
    @(posedge clk);
    wp <= 1'b0;
    // byte write in the upper half of the array
    wr_page(10'h155, 1, 1'b1);
    wait_prog();
    rd_chk(10'h155, 1);
    print_verdict();
  end
endmodule // testbench
